/* hdl/precise_exception_ordering.sv */
// Overview of operation
// - Exceptions are taken in program order except imprecise floating point, reset and machine check.
// - Conditions may be reported out of order but are dispatched to handlers in instruction order.
// - A precise instruction-caused exception waits until every older instruction has completed.
// - An exception raised by an older instruction is serviced before a younger pending one.
// - Asynchronous precise requests are latched at once and served only when nothing is in flight.
// - Every source is classed as synchronous precise or imprecise, or asynchronous maskable or not.
// - Taking an exception saves state and redirects fetch to a fixed vector per type.
// - Entering a handler always switches to supervisor privilege.
// - The four segment-register move instructions exist all together or not at all.
// - On a 64-bit core lacking that group, any of the four raises a program exception.
// - Taking an exception copies the exception byte order into the active byte order.
module precise_exception_ordering (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Issue into the completion window
   input wire logic issueValid,
   output logic issueReady,
   input wire logic [exc_order_pkg::ADDR_W-1:0] issuePc,
   input wire logic issueSegMove,
   output logic [exc_order_pkg::TAG_W-1:0] issueTag,
   // Completion reports
   input wire logic cmplValid,
   input wire logic [exc_order_pkg::TAG_W-1:0] cmplTag,
   input wire logic cmplExc,
   input wire exc_order_pkg::excCode_t cmplCode,
   // In-order retirement
   output logic retireValid,
   output logic [exc_order_pkg::TAG_W-1:0] retireTag,
   // Asynchronous sources
   input wire logic extReq,
   input wire logic decrReq,
   input wire logic mcheckReq,
   input wire logic resetReq,
   // Control state
   input wire logic intEnable,
   input wire logic fpImpreciseEn,
   input wire logic [exc_order_pkg::ADDR_W-1:0] resumePc,
   input wire logic stateWe,
   input wire logic stateActiveByteOrder,
   input wire logic stateExcByteOrder,
   input wire logic stateUser,
   // Exception entry
   output logic flush,
   output logic excTaken,
   output logic [exc_order_pkg::ADDR_W-1:0] excVector,
   output logic [exc_order_pkg::ADDR_W-1:0] excSavedPc,
   output logic excSavedByteOrder,
   output logic excSavedUser,
   output exc_order_pkg::excCode_t excCause,
   output exc_order_pkg::excClass_t excClass,
   // Processor state
   output logic activeByteOrder,
   output logic exceptionByteOrder,
   output logic operatingEnvLevel
);

   localparam int D = exc_order_pkg::ROB_DEPTH;

   // ---------------------------------------------------------------
   // Completion window
   // ---------------------------------------------------------------
   logic robValid_q [D];
   logic robValid_d [D];
   logic robDone_q [D];
   logic robDone_d [D];
   logic robExc_q [D];
   logic robExc_d [D];
   exc_order_pkg::excCode_t robCode_q [D];
   exc_order_pkg::excCode_t robCode_d [D];
   logic [exc_order_pkg::ADDR_W-1:0] robPc_q [D];
   logic [exc_order_pkg::ADDR_W-1:0] robPc_d [D];
   logic [exc_order_pkg::TAG_W-1:0] head_q, head_d, tail_q, tail_d;
   logic [exc_order_pkg::CNT_W-1:0] count_q, count_d;

   logic pendExt_q, pendExt_d, pendDecr_q, pendDecr_d;
   logic pendMc_q, pendMc_d, pendRst_q, pendRst_d;
   logic activeBo_q, activeBo_d, excBo_q, excBo_d, user_q, user_d;
   logic taken_q, taken_d, savedBo_q, savedBo_d, savedUser_q, savedUser_d;
   logic [exc_order_pkg::ADDR_W-1:0] vec_q, vec_d, savedPc_q, savedPc_d;
   exc_order_pkg::excCode_t cause_q, cause_d, takeCode;
   exc_order_pkg::excClass_t cls_q, cls_d;
   logic takeD, issueFire, asyncHold, headExc, segTrap;
   logic [exc_order_pkg::ADDR_W-1:0] takePc;

   exc_cause_if causeBus ();

   exc_classify u_classify (
      .cause(causeBus)
   );

   assign causeBus.code = takeCode;

   // A missing group traps as one; no member decodes on its own
   assign segTrap = issueSegMove & exc_order_pkg::CORE_IS_64BIT
      & ~exc_order_pkg::HAS_SEG_MOVE_GROUP;

   assign headExc = robValid_q[head_q] & robDone_q[head_q] & robExc_q[head_q];
   // Stop feeding the window so an enabled request can drain it
   assign asyncHold = intEnable & (pendExt_q | pendDecr_q);

   // ---------------------------------------------------------------
   // Decision of what is taken this cycle
   // ---------------------------------------------------------------
   always_comb begin
      takeD = 1'b1;
      takeCode = exc_order_pkg::EXC_NONE;
      takePc = (count_q != '0) ? robPc_q[head_q] : resumePc;
      if (pendRst_q) begin
         takeCode = exc_order_pkg::EXC_RESET;
      end else if (pendMc_q) begin
         takeCode = exc_order_pkg::EXC_MCHECK;
      end else if (cmplValid && cmplExc && fpImpreciseEn
                   && cmplCode == exc_order_pkg::EXC_FPIMPRECISE) begin
         takeCode = exc_order_pkg::EXC_FPIMPRECISE;
         takePc = robPc_q[cmplTag];
      end else if (headExc) begin
         // Only the oldest entry may take a precise trap, so older faults win
         takeCode = robCode_q[head_q];
      end else if (count_q == '0 && intEnable && pendExt_q) begin
         takeCode = exc_order_pkg::EXC_EXTERNAL;
      end else if (count_q == '0 && intEnable && pendDecr_q) begin
         takeCode = exc_order_pkg::EXC_DECR;
      end else begin
         takeD = 1'b0;
      end
   end

   assign issueReady = (count_q != exc_order_pkg::CNT_W'(D)) & ~asyncHold & ~takeD;
   assign issueFire = issueValid & issueReady;
   assign issueTag = tail_q;
   assign retireValid = ~takeD & robValid_q[head_q] & robDone_q[head_q] & ~robExc_q[head_q];
   assign retireTag = head_q;
   assign flush = takeD;

   // ---------------------------------------------------------------
   // Window and pending state, next values
   // ---------------------------------------------------------------
   always_comb begin
      robValid_d = robValid_q;
      robDone_d = robDone_q;
      robExc_d = robExc_q;
      robCode_d = robCode_q;
      robPc_d = robPc_q;
      head_d = head_q;
      tail_d = tail_q;
      count_d = count_q;
      if (cmplValid && robValid_q[cmplTag]) begin
         robDone_d[cmplTag] = 1'b1;
         if (cmplExc && !robExc_q[cmplTag]) begin
            robExc_d[cmplTag] = 1'b1;
            robCode_d[cmplTag] = cmplCode;
         end
      end
      if (issueFire) begin
         robValid_d[tail_q] = 1'b1;
         robDone_d[tail_q] = segTrap;
         robExc_d[tail_q] = segTrap;
         robCode_d[tail_q] = segTrap ? exc_order_pkg::EXC_PROGRAM : exc_order_pkg::EXC_NONE;
         robPc_d[tail_q] = issuePc;
         tail_d = tail_q + 1'b1;
      end
      if (retireValid) begin
         robValid_d[head_q] = 1'b0;
         head_d = head_q + 1'b1;
      end
      count_d = count_q + (issueFire ? 1'b1 : 1'b0) - (retireValid ? 1'b1 : 1'b0);
      if (takeD) begin
         for (int i = 0; i < D; i++) begin
            robValid_d[i] = 1'b0;
         end
         head_d = '0;
         tail_d = '0;
         count_d = '0;
      end
   end

   // New requests beat the clear of the one being taken
   always_comb begin
      pendExt_d = (pendExt_q & ~(takeD && takeCode == exc_order_pkg::EXC_EXTERNAL)) | extReq;
      pendDecr_d = (pendDecr_q & ~(takeD && takeCode == exc_order_pkg::EXC_DECR)) | decrReq;
      pendMc_d = (pendMc_q & ~(takeD && takeCode == exc_order_pkg::EXC_MCHECK)) | mcheckReq;
      pendRst_d = (pendRst_q & ~(takeD && takeCode == exc_order_pkg::EXC_RESET)) | resetReq;
   end

   // ---------------------------------------------------------------
   // Processor state and saved state, next values
   // ---------------------------------------------------------------
   always_comb begin
      activeBo_d = activeBo_q;
      excBo_d = excBo_q;
      user_d = user_q;
      savedBo_d = savedBo_q;
      savedUser_d = savedUser_q;
      savedPc_d = savedPc_q;
      vec_d = vec_q;
      cause_d = cause_q;
      cls_d = cls_q;
      taken_d = takeD;
      if (stateWe) begin
         activeBo_d = stateActiveByteOrder;
         excBo_d = stateExcByteOrder;
         user_d = stateUser;
      end
      if (takeD) begin
         savedPc_d = takePc;
         savedBo_d = activeBo_q;
         savedUser_d = user_q;
         vec_d = causeBus.vector;
         cause_d = takeCode;
         cls_d = causeBus.cls;
         activeBo_d = excBo_q;
         user_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < D; i++) begin
            robValid_q[i] <= 1'b0;
            robDone_q[i] <= 1'b0;
            robExc_q[i] <= 1'b0;
            robCode_q[i] <= exc_order_pkg::EXC_NONE;
            robPc_q[i] <= '0;
         end
         head_q <= '0;
         tail_q <= '0;
         count_q <= '0;
         pendExt_q <= 1'b0;
         pendDecr_q <= 1'b0;
         pendMc_q <= 1'b0;
         pendRst_q <= 1'b0;
         activeBo_q <= exc_order_pkg::RST_ACTIVE_BYTE_ORDER;
         excBo_q <= exc_order_pkg::RST_EXC_BYTE_ORDER;
         user_q <= exc_order_pkg::RST_USER_MODE;
         taken_q <= 1'b0;
         savedBo_q <= 1'b0;
         savedUser_q <= 1'b0;
         savedPc_q <= '0;
         vec_q <= '0;
         cause_q <= exc_order_pkg::EXC_NONE;
         cls_q <= exc_order_pkg::CLS_SYNC_PRECISE;
      end else begin
         robValid_q <= robValid_d;
         robDone_q <= robDone_d;
         robExc_q <= robExc_d;
         robCode_q <= robCode_d;
         robPc_q <= robPc_d;
         head_q <= head_d;
         tail_q <= tail_d;
         count_q <= count_d;
         pendExt_q <= pendExt_d;
         pendDecr_q <= pendDecr_d;
         pendMc_q <= pendMc_d;
         pendRst_q <= pendRst_d;
         activeBo_q <= activeBo_d;
         excBo_q <= excBo_d;
         user_q <= user_d;
         taken_q <= taken_d;
         savedBo_q <= savedBo_d;
         savedUser_q <= savedUser_d;
         savedPc_q <= savedPc_d;
         vec_q <= vec_d;
         cause_q <= cause_d;
         cls_q <= cls_d;
      end
   end

   assign excTaken = taken_q;
   assign excVector = vec_q;
   assign excSavedPc = savedPc_q;
   assign excSavedByteOrder = savedBo_q;
   assign excSavedUser = savedUser_q;
   assign excCause = cause_q;
   assign excClass = cls_q;
   assign activeByteOrder = activeBo_q;
   assign exceptionByteOrder = excBo_q;
   assign operatingEnvLevel = ~user_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seqDecide;
      takeD && !stateWe;
   endsequence

   sequence seqEntered;
      excTaken && operatingEnvLevel && excVector == $past(causeBus.vector);
   endsequence

   chk_entry_vector: assert property (seqDecide |=> seqEntered)
      else $error("exception entry lacks supervisor level or vector");
   chk_enter_super: assert property (takeD && stateWe |=> operatingEnvLevel)
      else $error("handler entered without supervisor level");
   chk_byte_order_copy: assert property (
      takeD |=> activeByteOrder == $past(exceptionByteOrder))
      else $error("exception byte order not copied");
   chk_sync_from_head: assert property (
      takeD && causeBus.cls == exc_order_pkg::CLS_SYNC_PRECISE
      |-> headExc && !pendRst_q && !pendMc_q)
      else $error("precise exception taken off the oldest entry");
   chk_async_drained: assert property (
      takeD && causeBus.cls == exc_order_pkg::CLS_ASYNC_MASKABLE
      |-> count_q == '0 && !headExc)
      else $error("asynchronous precise exception taken with work in flight");
   chk_mask_gate: assert property (
      takeD && causeBus.cls == exc_order_pkg::CLS_ASYNC_MASKABLE |-> intEnable)
      else $error("masked source taken");
   chk_nonmask_now: assert property (
      resetReq |=> takeD && takeCode == exc_order_pkg::EXC_RESET)
      else $error("reset request not taken next cycle");
   chk_seg_trap: assert property (
      issueFire && segTrap |=> robExc_q[$past(tail_q)]
      && robCode_q[$past(tail_q)] == exc_order_pkg::EXC_PROGRAM)
      else $error("segment move not marked as program exception");
   chk_retire_order: assert property (
      retireValid |=> count_q == $past(count_q) - 1'b1 + ($past(issueFire) ? 1'b1 : 1'b0)
      && head_q == $past(head_q) + 1'b1)
      else $error("retirement out of order");

endmodule : precise_exception_ordering

/* hdl/exc_order_pkg.sv */
package exc_order_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int ADDR_W = 64;
   localparam int ROB_DEPTH = 8;
   localparam int TAG_W = 3;
   localparam int CNT_W = 4;

   // ---------------------------------------------------------------
   // Core options
   // ---------------------------------------------------------------
   localparam logic CORE_IS_64BIT = 1'b1;
   localparam logic HAS_SEG_MOVE_GROUP = 1'b0;

   // ---------------------------------------------------------------
   // Vectors
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] VEC_BASE = 64'h0000_0000_0000_0000;
   localparam int VEC_SHIFT = 8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic BYTE_ORDER_BIG = 1'b0;
   localparam logic BYTE_ORDER_LITTLE = 1'b1;
   localparam logic RST_ACTIVE_BYTE_ORDER = BYTE_ORDER_BIG;
   localparam logic RST_EXC_BYTE_ORDER = BYTE_ORDER_BIG;
   localparam logic RST_USER_MODE = 1'b0;

   typedef enum logic [3:0] {
      EXC_NONE,
      EXC_RESET,
      EXC_MCHECK,
      EXC_DSTORAGE,
      EXC_ISTORAGE,
      EXC_EXTERNAL,
      EXC_ALIGN,
      EXC_PROGRAM,
      EXC_FPUNAVAIL,
      EXC_DECR,
      EXC_SYSCALL,
      EXC_FPIMPRECISE
   } excCode_t;

   typedef enum logic [1:0] {
      CLS_SYNC_PRECISE,
      CLS_SYNC_IMPRECISE,
      CLS_ASYNC_MASKABLE,
      CLS_ASYNC_NONMASKABLE
   } excClass_t;

endpackage : exc_order_pkg

/* hdl/exc_cause_if.sv */
interface exc_cause_if;
   exc_order_pkg::excCode_t code;
   exc_order_pkg::excClass_t cls;
   logic [exc_order_pkg::ADDR_W-1:0] vector;

   modport requester (output code, input cls, input vector);
   modport classifier (input code, output cls, output vector);
endinterface : exc_cause_if

/* hdl/exc_classify.sv */
module exc_classify (
   exc_cause_if.classifier cause
);

   // ---------------------------------------------------------------
   // Class of each source
   // ---------------------------------------------------------------
   always_comb begin
      case (cause.code)
         exc_order_pkg::EXC_RESET,
         exc_order_pkg::EXC_MCHECK: begin
            cause.cls = exc_order_pkg::CLS_ASYNC_NONMASKABLE;
         end
         exc_order_pkg::EXC_EXTERNAL,
         exc_order_pkg::EXC_DECR: begin
            cause.cls = exc_order_pkg::CLS_ASYNC_MASKABLE;
         end
         exc_order_pkg::EXC_FPIMPRECISE: begin
            cause.cls = exc_order_pkg::CLS_SYNC_IMPRECISE;
         end
         default: begin
            cause.cls = exc_order_pkg::CLS_SYNC_PRECISE;
         end
      endcase
   end

   // One fixed vector per type
   assign cause.vector = exc_order_pkg::VEC_BASE
      + (exc_order_pkg::ADDR_W'(cause.code) << exc_order_pkg::VEC_SHIFT);

endmodule : exc_classify

/* verif/pipe_partner.sv */
module pipe_partner (
   // Clock
   input wire logic clk,
   // Issue
   input wire logic issueReady,
   output logic issueValid,
   output logic [exc_order_pkg::ADDR_W-1:0] issuePc,
   output logic issueSegMove,
   // Completion
   output logic cmplValid,
   output logic [exc_order_pkg::TAG_W-1:0] cmplTag,
   output logic cmplExc,
   output exc_order_pkg::excCode_t cmplCode
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      issueValid = 1'b0;
      issuePc = 64'h0;
      issueSegMove = 1'b0;
      cmplValid = 1'b0;
      cmplTag = 3'h0;
      cmplExc = 1'b0;
      cmplCode = exc_order_pkg::EXC_NONE;
   end

   // Ready is looked at mid-cycle so a flush landing on the edge cannot race
   task automatic issue(input logic [63:0] pc, input logic seg, input bit last);
      issueValid = 1'b1;
      issuePc = pc;
      issueSegMove = seg;
      do @(negedge clk); while (issueReady !== 1'b1);
      @(posedge clk);
      #1;
      if (last) begin
         issueValid = 1'b0;
         issuePc = ~pc;
         issueSegMove = ~seg;
      end
   endtask : issue

   // Gap gives a slow answer; released fields carry junk
   task automatic complete(input logic [2:0] tag, input logic exc,
                           input exc_order_pkg::excCode_t code, input int gap);
      repeat (gap) begin
         @(posedge clk);
         #1;
      end
      cmplValid = 1'b1;
      cmplTag = tag;
      cmplExc = exc;
      cmplCode = code;
      @(posedge clk);
      #1;
      cmplValid = 1'b0;
      cmplTag = ~tag;
      cmplExc = ~exc;
      cmplCode = exc_order_pkg::excCode_t'(~code);
      @(posedge clk);
      #1;
   endtask : complete
endmodule : pipe_partner

/* verif/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // Design and partner
   // ------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic issueValid, issueReady, issueSegMove, cmplValid, cmplExc, retireValid;
   logic [63:0] issuePc, excVector, excSavedPc;
   logic [63:0] resumePc = 64'h0;
   logic [2:0] issueTag, cmplTag, retireTag;
   exc_order_pkg::excCode_t cmplCode, excCause;
   exc_order_pkg::excClass_t excClass;
   logic extReq = 1'b0, decrReq = 1'b0, mcheckReq = 1'b0, resetReq = 1'b0;
   logic intEnable = 1'b0, fpImpreciseEn = 1'b0, stateWe = 1'b0;
   logic stateActiveByteOrder = 1'b0, stateExcByteOrder = 1'b0, stateUser = 1'b0;
   logic flush, excTaken, excSavedByteOrder, excSavedUser;
   logic activeByteOrder, exceptionByteOrder, operatingEnvLevel;
   int errCount = 0;
   int totalChecks = 0;
   logic [31:0] rngState = 32'h6eb7;
   int retQ[$];
   logic [63:0] p[3];
   logic flushSeen;

   always #5 clk = ~clk;

   pipe_partner pipe_partner_inst (.clk, .issueReady, .issueValid, .issuePc, .issueSegMove,
      .cmplValid, .cmplTag, .cmplExc, .cmplCode);
   precise_exception_ordering precise_exception_ordering_inst (.clk, .rst_n, .issueValid,
      .issueReady, .issuePc, .issueSegMove, .issueTag, .cmplValid, .cmplTag, .cmplExc,
      .cmplCode, .retireValid, .retireTag, .extReq, .decrReq, .mcheckReq, .resetReq,
      .intEnable, .fpImpreciseEn, .resumePc, .stateWe, .stateActiveByteOrder,
      .stateExcByteOrder, .stateUser, .flush, .excTaken, .excVector, .excSavedPc,
      .excSavedByteOrder, .excSavedUser, .excCause, .excClass, .activeByteOrder,
      .exceptionByteOrder, .operatingEnvLevel);

   // ------------------------------
   // Model and checks
   // ------------------------------
   function automatic logic [63:0] rnd();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return {rngState, rngState ^ 32'h5a5a_0f0f};
   endfunction : rnd

   function automatic exc_order_pkg::excClass_t clsOf(exc_order_pkg::excCode_t c);
      case (c)
         exc_order_pkg::EXC_EXTERNAL, exc_order_pkg::EXC_DECR:
            return exc_order_pkg::CLS_ASYNC_MASKABLE;
         exc_order_pkg::EXC_RESET, exc_order_pkg::EXC_MCHECK:
            return exc_order_pkg::CLS_ASYNC_NONMASKABLE;
         exc_order_pkg::EXC_FPIMPRECISE: return exc_order_pkg::CLS_SYNC_IMPRECISE;
         default: return exc_order_pkg::CLS_SYNC_PRECISE;
      endcase
   endfunction : clsOf

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      totalChecks++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Waits a bounded span for entry, then checks cause, class, vector, saved pc and level, not saved byte order or user
   task automatic chkExc(input exc_order_pkg::excCode_t code, input logic [63:0] pc);
      int n;
      n = 0;
      while (excTaken !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("excTaken", 64'h1, 64'(excTaken));
      chk("flush", 64'h1, 64'(flushSeen));
      chk("excCause", 64'(code), 64'(excCause));
      chk("excClass", 64'(clsOf(code)), 64'(excClass));
      chk("excVector", exc_order_pkg::VEC_BASE + (64'(code) << exc_order_pkg::VEC_SHIFT),
          excVector);
      chk("excSavedPc", pc, excSavedPc);
      chk("operatingEnvLevel", 64'h1, 64'(operatingEnvLevel));
      chk("pendingRetires", 64'h0, 64'(retQ.size()));
   endtask : chkExc

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         chk("excTaken", 64'h0, 64'(excTaken));
         chk("flush", 64'h0, 64'(flushSeen));
      end
   endtask : quiet

   task automatic doReset();
      rst_n = 1'b0;
      intEnable = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      retQ = {};
      foreach (p[i]) p[i] = rnd();
      chk("issueReady", 64'h1, 64'(issueReady));
      chk("operatingEnvLevel", 64'h1, 64'(operatingEnvLevel));
      chk("activeByteOrder", 64'h0, 64'(activeByteOrder));
      chk("exceptionByteOrder", 64'h0, 64'(exceptionByteOrder));
      chk("issueTag", 64'h0, 64'(issueTag));
   endtask : doReset

   // Flush is combinational; its value just before each edge is kept
   always @(negedge clk) flushSeen = flush;

   // Retire pulse stands a cycle, so it is read mid-cycle
   always @(negedge clk) begin
      if (rst_n && retireValid === 1'b1) begin
         chk("retireTag", retQ.size() ? 64'(retQ.pop_front()) : 64'hff, 64'(retireTag));
      end
   end

   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tallyAndFinish

   initial begin
      #50us;
      errCount++;
      $display("watchdog expired");
      tallyAndFinish();
   end

   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      doReset();
      stateWe = 1'b1;
      stateExcByteOrder = 1'b1;
      stateUser = 1'b1;
      @(posedge clk);
      #1;
      stateWe = 1'b0;
      pipe_partner_inst.issue(p[0], 1'b0, 1'b0);
      pipe_partner_inst.issue(p[1], 1'b0, 1'b0);
      pipe_partner_inst.issue(p[2], 1'b0, 1'b1);
      retQ = {0, 1};
      pipe_partner_inst.complete(3'd2, 1'b1, exc_order_pkg::EXC_ALIGN, 0);
      pipe_partner_inst.complete(3'd1, 1'b0, exc_order_pkg::EXC_NONE, 1);
      quiet(3);
      pipe_partner_inst.complete(3'd0, 1'b0, exc_order_pkg::EXC_NONE, 0);
      chkExc(exc_order_pkg::EXC_ALIGN, p[2]);
      chk("activeByteOrder", 64'h1, 64'(activeByteOrder));
      chk("exceptionByteOrder", 64'h1, 64'(exceptionByteOrder));
      chk("excSavedByteOrder", 64'h0, 64'(excSavedByteOrder));
      chk("excSavedUser", 64'h1, 64'(excSavedUser));
      $display("test ordered completion done");

      doReset();
      pipe_partner_inst.issue(p[0], 1'b0, 1'b0);
      pipe_partner_inst.issue(p[1], 1'b0, 1'b1);
      pipe_partner_inst.complete(3'd1, 1'b1, exc_order_pkg::EXC_ALIGN, 0);
      pipe_partner_inst.complete(3'd0, 1'b1, exc_order_pkg::EXC_DSTORAGE, 2);
      chkExc(exc_order_pkg::EXC_DSTORAGE, p[0]);
      $display("test older first done");

      for (int k = 0; k < 2; k++) begin
         doReset();
         intEnable = 1'b1;
         resumePc = rnd();
         pipe_partner_inst.issue(p[0], 1'b0, 1'b1);
         extReq = (k == 0);
         decrReq = (k == 1);
         @(posedge clk);
         #1;
         extReq = 1'b0;
         decrReq = 1'b0;
         chk("issueReady", 64'h0, 64'(issueReady));
         quiet(3);
         retQ = {0};
         pipe_partner_inst.complete(3'd0, 1'b0, exc_order_pkg::EXC_NONE, 0);
         chkExc(k ? exc_order_pkg::EXC_DECR : exc_order_pkg::EXC_EXTERNAL, resumePc);
      end
      $display("test maskable async done");

      for (int k = 0; k < 2; k++) begin
         doReset();
         pipe_partner_inst.issue(p[0], 1'b0, 1'b1);
         decrReq = 1'b1;
         quiet(5);
         decrReq = 1'b0;
         mcheckReq = (k == 0);
         resetReq = (k == 1);
         @(posedge clk);
         #1;
         mcheckReq = 1'b0;
         resetReq = 1'b0;
         // A state load in the entry cycle must lose to the exception
         stateWe = 1'b1;
         stateUser = 1'b1;
         chkExc(k ? exc_order_pkg::EXC_RESET : exc_order_pkg::EXC_MCHECK,
                p[0]);
         stateWe = 1'b0;
         chk("excSavedUser", 64'h0, 64'(excSavedUser));
      end
      $display("test nonmaskable done");

      doReset();
      pipe_partner_inst.issue(p[0], 1'b0, 1'b0);
      pipe_partner_inst.issue(p[1], 1'b1, 1'b1);
      quiet(3);
      retQ = {0};
      pipe_partner_inst.complete(3'd0, 1'b0, exc_order_pkg::EXC_NONE, 0);
      chkExc(exc_order_pkg::EXC_PROGRAM, p[1]);
      $display("test segment move done");

      doReset();
      fpImpreciseEn = 1'b1;
      pipe_partner_inst.issue(p[0], 1'b0, 1'b0);
      pipe_partner_inst.issue(p[1], 1'b0, 1'b1);
      // Taken on the report itself, ahead of the older slot still in flight
      fork
         pipe_partner_inst.complete(3'd1, 1'b1, exc_order_pkg::EXC_FPIMPRECISE, 0);
         chkExc(exc_order_pkg::EXC_FPIMPRECISE, p[1]);
      join
      fpImpreciseEn = 1'b0;
      $display("test imprecise report done");
      tallyAndFinish();
   end
endmodule : testbench
